// >>> verilog/dccs_top.sv
// Daisy-chain configuration shifter: serial shadow chain, load latch, SIGNAL_LOST_FLAG muting
//
// Overview of operation
// - Deselected device ignores shared serial data.
// - Overflow bits leave on serial output.
// - New bit enters stage one, shifts upward.
// - Stage 21 bit drives output same cycle.
// - Serial output equals input delayed 20 clocks.
// - First 20 output bits are undefined.
// - Serial output changes only after rising edge.
// - Mute each channel while loss persists.
// - Sample on rising edges, keep last 21.
// - Select rising latches shadow into active settings; here it is queued, applied on cfg_apply_ready_in, refused when queue full.
`timescale 1ns/1ps
`default_nettype none

module dccs_top (
  // Clock, reset, enable
  input  wire logic                         ref_clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic                         ce_in,
  // Serial configuration pins
  input  wire logic                         serial_clk_in,
  input  wire logic                         serial_cfg_in,
  input  wire logic                         cfg_load_select_n_in,
  output logic                              serial_cfg_out,
  // Loss-of-signal monitoring
  input  wire logic [dccs_pkg::CH_N-1:0]    signal_lost_flag_in,
  output logic      [dccs_pkg::CH_N-1:0]    chan_mute_out,
  // Active configuration
  input  wire logic                         cfg_apply_ready_in,
  output logic                              cfg_accept_ready_out,
  output logic                              cfg_pending_out,
  output logic                              cfg_applied_out,
  output dccs_pkg::dccs_cfg_t               cfg_active_out
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  // Stage 1 feeds only stage 2; stage 3 is the edge-detect history
  dccs_pkg::dccs_pins_t pins_raw;
  dccs_pkg::dccs_pins_t pins_s1_r;
  dccs_pkg::dccs_pins_t pins_s2_r;
  dccs_pkg::dccs_pins_t pins_s3_r;
  dccs_pkg::dccs_pins_t pins_s1_nxt;
  dccs_pkg::dccs_pins_t pins_s2_nxt;
  dccs_pkg::dccs_pins_t pins_s3_nxt;

  always_comb begin
    pins_raw.clk   = serial_clk_in;
    pins_raw.data  = serial_cfg_in;
    pins_raw.sel_n = cfg_load_select_n_in;
    pins_s1_nxt    = ce_in ? pins_raw  : pins_s1_r;
    pins_s2_nxt    = ce_in ? pins_s1_r : pins_s2_r;
    pins_s3_nxt    = ce_in ? pins_s2_r : pins_s3_r;
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_s1_r <= dccs_pkg::PINS_RST;
      pins_s2_r <= dccs_pkg::PINS_RST;
      pins_s3_r <= dccs_pkg::PINS_RST;
    end else begin
      pins_s1_r <= pins_s1_nxt;
      pins_s2_r <= pins_s2_nxt;
      pins_s3_r <= pins_s3_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------------------
  // Data and clock share sync depth, so data is sampled as it stood at the edge
  // History resets to the idle pin levels, so no false edge follows reset
  // Limitation: each serial clock phase must span three reference cycles
  logic sclk_rise;
  logic sel_rise;
  logic shift_en;

  always_comb begin
    sclk_rise = pins_s2_r.clk && !pins_s3_r.clk;
    sel_rise  = pins_s2_r.sel_n && !pins_s3_r.sel_n;
    shift_en  = ce_in && sclk_rise && !pins_s2_r.sel_n;
  end

  // ---------------------------------------------------------------------------
  // Shadow chain
  // ---------------------------------------------------------------------------
  // Index k holds shadow stage k+1; older bits move to higher stages
  logic [dccs_pkg::CHAIN_LEN-1:0] shadow_r;
  logic [dccs_pkg::CHAIN_LEN-1:0] shadow_nxt;

  always_comb begin
    shadow_nxt = shadow_r;
    if (shift_en) begin
      shadow_nxt = {shadow_r[dccs_pkg::CHAIN_LEN-2:0], pins_s2_r.data};
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      shadow_r <= dccs_pkg::SHADOW_RST;
    end else begin
      shadow_r <= shadow_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------------------
  // Top stage is a flop, so the output moves only on a detected clock rise
  // and shows the bit in the same update that brings it into stage 21.
  // Through the first 20 rises it shows reset filler, not real data.
  // Held while deselected, so a chained neighbour sees no stray edges
  always_comb begin
    serial_cfg_out = shadow_r[dccs_pkg::OUT_STAGE];
  end

  // ---------------------------------------------------------------------------
  // Load path
  // ---------------------------------------------------------------------------
  // Shifting never touches the active word; only a select release queues it.
  // If the queue is full the new word is refused; cfg_accept_ready_out warns.
  // Trade-off: the queue rides out a stalled consumer at the cost of area.
  logic                              q_out_valid;
  logic                              q_out_ready;
  logic [dccs_pkg::CHAIN_LEN-1:0]    q_out_data;

  dccs_fifo #(
    .WIDTH (dccs_pkg::CHAIN_LEN),
    .DEPTH (dccs_pkg::FIFO_DEPTH)
  ) u_load_fifo (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .ce_in         (ce_in),
    .in_valid_in   (sel_rise),
    .in_ready_out  (cfg_accept_ready_out),
    .in_data_in    (shadow_r),
    .out_valid_out (q_out_valid),
    .out_ready_in  (q_out_ready),
    .out_data_out  (q_out_data)
  );

  // ---------------------------------------------------------------------------
  // Active configuration
  // ---------------------------------------------------------------------------
  dccs_pkg::dccs_cfg_t active_r;
  dccs_pkg::dccs_cfg_t active_nxt;
  logic                applied_r;
  logic                applied_nxt;

  // Applied is a one-cycle strobe; the word holds until the next pop.
  // Reset word has the override clear, so pins keep control until a load.
  always_comb begin
    q_out_ready = cfg_apply_ready_in;
    active_nxt  = active_r;
    applied_nxt = ce_in ? 1'h0 : applied_r;
    if (ce_in && q_out_valid && q_out_ready) begin
      active_nxt  = dccs_pkg::dccs_cfg_t'(q_out_data);
      applied_nxt = 1'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      active_r  <= dccs_pkg::dccs_cfg_t'(dccs_pkg::SHADOW_RST);
      applied_r <= dccs_pkg::BIT_RST;
    end else begin
      active_r  <= active_nxt;
      applied_r <= applied_nxt;
    end
  end

  always_comb begin
    cfg_active_out  = active_r;
    cfg_applied_out = applied_r;
    cfg_pending_out = q_out_valid;
  end

  // ---------------------------------------------------------------------------
  // Per-channel loss-of-signal muting
  // ---------------------------------------------------------------------------
  // Muted from reset until the detector is seen settled
  // Flags are plain levels from the detector, so no edge logic is needed
  logic [dccs_pkg::CH_N-1:0] los_s1_r;
  logic [dccs_pkg::CH_N-1:0] los_s2_r;

  genvar ch;
  generate
    for (ch = 0; ch < dccs_pkg::CH_N; ch++) begin : g_chan
      logic s1_nxt;
      logic s2_nxt;

      always_comb begin
        s1_nxt = ce_in ? signal_lost_flag_in[ch] : los_s1_r[ch];
        s2_nxt = ce_in ? los_s1_r[ch] : los_s2_r[ch];
      end

      always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          los_s1_r[ch] <= dccs_pkg::MUTE_RST[ch];
          los_s2_r[ch] <= dccs_pkg::MUTE_RST[ch];
        end else begin
          los_s1_r[ch] <= s1_nxt;
          los_s2_r[ch] <= s2_nxt;
        end
      end

      always_comb begin
        chan_mute_out[ch] = los_s2_r[ch];
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> verilog/dccs_pkg.sv
// Shared constants and carrier types of the daisy-chain configuration shifter
package dccs_pkg;

  // ---------------------------------------------------------------------------
  // Chain geometry
  // ---------------------------------------------------------------------------
  localparam int CHAIN_LEN  = 21;
  localparam int CH_N       = 4;
  localparam int BOOST_W    = 5;
  localparam int OVR_POS    = 0;
  localparam int BOOST_BASE = 1;
  localparam int OUT_STAGE  = CHAIN_LEN - 1;
  localparam int SYNC_W     = 2;

  // ---------------------------------------------------------------------------
  // Buffering
  // ---------------------------------------------------------------------------
  localparam int FIFO_DEPTH = 4;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [CHAIN_LEN-1:0] SHADOW_RST = 21'h000000;
  localparam logic [CH_N-1:0]      MUTE_RST   = 4'hF;
  localparam logic                 BIT_RST    = 1'h0;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  // Bit 0 is the pin-override flag, then five boost bits per channel, LSB first
  typedef struct packed {
    logic [CH_N-1:0][BOOST_W-1:0] boost;
    logic                         override;
  } dccs_cfg_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic sel_n;
  } dccs_pins_t;

  localparam dccs_pins_t PINS_RST = 3'h1;

endpackage

// >>> verilog/dccs_fifo.sv
// Parameterised valid/ready FIFO carrying latched configuration words
`timescale 1ns/1ps
`default_nettype none

module dccs_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             ce_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      wr_ptr_nxt;
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      rd_ptr_nxt;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------------------
  // Status and next pointers
  // ---------------------------------------------------------------------------
  always_comb begin
    empty         = (wr_ptr_r == rd_ptr_r);
    full          = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    in_ready_out  = !full;
    out_valid_out = !empty;
    out_data_out  = mem_r[rd_ptr_r[AW-1:0]];
    push          = ce_in && in_valid_in && !full;
    pop           = ce_in && out_ready_in && !empty;
    wr_ptr_nxt    = push ? wr_ptr_r + (AW+1)'(1) : wr_ptr_r;
    rd_ptr_nxt    = pop  ? rd_ptr_r + (AW+1)'(1) : rd_ptr_r;
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // Storage has no reset; words are only read once written
  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

endmodule

`default_nettype wire

// >>> tb/dccs_checker.sv
// Port-level assertions for the configuration shifter
`timescale 1ns/1ps
`default_nettype none
module dccs_checker (
  // Clock, reset and serial pins
  input wire logic                      ref_clk_in,
  input wire logic                      arst_n_in,
  input wire logic                      ce_in,
  input wire logic                      serial_clk_in,
  input wire logic                      cfg_load_select_n_in,
  input wire logic                      serial_cfg_out,
  // Muting and load path
  input wire logic [dccs_pkg::CH_N-1:0] signal_lost_flag_in,
  input wire logic [dccs_pkg::CH_N-1:0] chan_mute_out,
  input wire logic                      cfg_apply_ready_in,
  input wire logic                      cfg_accept_ready_out,
  input wire logic                      cfg_pending_out,
  input wire logic                      cfg_applied_out,
  input wire dccs_pkg::dccs_cfg_t       cfg_active_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Two sync stages between flag and mute
  a_mute_follow: assert property ($past(arst_n_in) && $past(arst_n_in, 2) &&
    $past(ce_in) && $past(ce_in, 2) |->
    chan_mute_out == $past(signal_lost_flag_in, 2)) else $error("mute not tracking flag");
  a_out_on_rise: assert property ($changed(serial_cfg_out) |->
    $past(serial_clk_in, 3) && !$past(cfg_load_select_n_in, 3)) else $error("output moved alone");
  a_out_desel: assert property (cfg_load_select_n_in [*6] |=>
    $stable(serial_cfg_out)) else $error("output moved while deselected");
  a_apply_pulse: assert property (cfg_pending_out && cfg_apply_ready_in && ce_in |=>
    cfg_applied_out) else $error("pop without applied pulse");
  a_no_stall_pop: assert property (!cfg_apply_ready_in |=>
    !cfg_applied_out) else $error("applied while consumer stalled");
  a_active_hold: assert property (!cfg_applied_out |->
    $stable(cfg_active_out)) else $error("active word changed without apply");
  a_load_push: assert property ($rose(cfg_load_select_n_in) && cfg_accept_ready_out |->
    ##[1:5] cfg_pending_out) else $error("load not queued");
  a_full_nonempty: assert property (!cfg_accept_ready_out |->
    cfg_pending_out) else $error("full yet empty");
  c_full: cover property (!cfg_accept_ready_out);
  c_applied: cover property (cfg_applied_out);
  c_shift_out: cover property ($changed(serial_cfg_out));
endmodule
`default_nettype wire

// >>> tb/dccs_ctrl_model.sv
// Behavioural serial controller driving the shifter pins
`timescale 1ns/1ps
`default_nettype none
module dccs_ctrl_model (
  // Timing reference
  input  wire logic ref_clk_in,
  // Serial pins
  output var logic  serial_clk_out,
  output var logic  cfg_data_out,
  output var logic  cfg_load_select_n_out
);
  initial begin
    serial_clk_out = 1'h0;
    cfg_data_out = 1'h0;
    cfg_load_select_n_out = 1'h1;
  end
  task automatic wait_neg(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  // Half periods of 32 ns give the 64 ns link period, far below the limit
  task automatic pulse(input logic b);
    cfg_data_out = b;
    #32;
    serial_clk_out = 1'h1;
    #32;
    serial_clk_out = 1'h0;
  endtask
  // One device only, so its select is the only one low
  task automatic open_frame();
    cfg_load_select_n_out = 1'h0;
    wait_neg(4);
  endtask
  // Chain of one: 21 bits a load; data line scrambled once released;
  // select stays high long enough for the load edge to be seen
  task automatic close_frame();
    wait_neg(4);
    cfg_load_select_n_out = 1'h1;
    cfg_data_out = ~cfg_data_out;
    wait_neg(4);
  endtask
endmodule
`default_nettype wire

// >>> tb/test_daisy_chain_config_shifter.sv
// Self-checking bench for the configuration shifter
`timescale 1ns/1ps
`default_nettype none
module test_daisy_chain_config_shifter;
  logic                           ref_clk_in = 1'h0;
  logic                           arst_n_in = 1'h0;
  logic                           ready = 1'h1;
  logic                           ce = 1'h1;
  logic [dccs_pkg::CH_N-1:0]      held;
  logic [dccs_pkg::CH_N-1:0]      flags = 4'h0;
  logic                           sclk, sdat, seln, sout, acc, pend, appl;
  logic [dccs_pkg::CH_N-1:0]      mute;
  dccs_pkg::dccs_cfg_t            act;
  logic [dccs_pkg::CHAIN_LEN-1:0] sh = dccs_pkg::SHADOW_RST;
  logic                           bq[$];
  dccs_pkg::dccs_cfg_t            wq[$];
  int                             num_errors = 0;
  int                             checks = 0;
  int                             rises = 0;
  int                             seed = 32'h1848;
  always #2.5 ref_clk_in = ~ref_clk_in;
  dccs_ctrl_model ctrl (.ref_clk_in(ref_clk_in), .serial_clk_out(sclk), .cfg_data_out(sdat),
    .cfg_load_select_n_out(seln));
  dccs_top dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
    .serial_clk_in(sclk), .serial_cfg_in(sdat), .cfg_load_select_n_in(seln),
    .serial_cfg_out(sout), .signal_lost_flag_in(flags), .chan_mute_out(mute),
    .cfg_apply_ready_in(ready), .cfg_accept_ready_out(acc), .cfg_pending_out(pend),
    .cfg_applied_out(appl), .cfg_active_out(act));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic send(input logic b);
    if (!seln) begin
      sh = {sh[dccs_pkg::CHAIN_LEN-2:0], b};
      bq.push_back(b);
    end
    ctrl.pulse(b);
  endtask
  // Register 21 first; extra leading bits are random overflow
  task automatic frame(input int n, input logic [20:0] w);
    ctrl.open_frame();
    for (int i = n - 1; i >= 0; i--) begin
      send(i > 20 ? 1'($random(seed)) : w[i]);
    end
    if (acc) wq.push_back(sh);
    ctrl.close_frame();
  endtask
  // First 20 outputs are filler and skipped
  always @(posedge sclk) begin
    if (!seln) begin
      rises++;
      repeat (6) @(negedge ref_clk_in);
      if (rises > 20) chk("serial_out", sout, bq.pop_front());
    end
  end
  always @(negedge ref_clk_in) begin
    if (appl === 1'h1) chk("active_word", act, wq.pop_front());
  end
  initial begin
    repeat (4) @(negedge ref_clk_in);
    chk("mute_reset", mute, dccs_pkg::MUTE_RST);
    arst_n_in = 1'h1;
    repeat (2) @(negedge ref_clk_in);
    frame(21, 21'h15A5C3);
    frame(30, 21'($random(seed)));
    // Clocks while deselected must leave the chain alone
    repeat (5) send(1'($random(seed)));
    frame(0, 21'h0);
    ready = 1'h0;
    for (int k = 0; k < 5; k++) begin
      if (k == 4) chk("accept_ready", acc, 1'h0);
      frame(2, 21'($random(seed)));
      repeat (8) @(negedge ref_clk_in);
    end
    ready = 1'h1;
    repeat (10) @(negedge ref_clk_in);
    chk("pending", pend, 1'h0);
    chk("words_left", wq.size(), 0);
    for (int k = 0; k < 8; k++) begin
      flags = 4'($random(seed));
      repeat (3) @(negedge ref_clk_in);
      chk("mute", mute, flags);
    end
    // Clock enable low must freeze the mute path
    held = flags;
    ce = 1'h0;
    flags = ~held;
    repeat (4) @(negedge ref_clk_in);
    chk("mute_frozen", mute, held);
    ce = 1'h1;
    repeat (3) @(negedge ref_clk_in);
    chk("mute_thawed", mute, flags);
    tally_and_finish();
  end
  // Run needs about 1000 cycles; this allows twenty times that
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
endmodule
bind dccs_top dccs_checker chk_i (
  .ref_clk_in           (ref_clk_in),
  .arst_n_in            (arst_n_in),
  .ce_in                (ce_in),
  .serial_clk_in        (serial_clk_in),
  .cfg_load_select_n_in (cfg_load_select_n_in),
  .serial_cfg_out       (serial_cfg_out),
  .signal_lost_flag_in  (signal_lost_flag_in),
  .chan_mute_out        (chan_mute_out),
  .cfg_apply_ready_in   (cfg_apply_ready_in),
  .cfg_accept_ready_out (cfg_accept_ready_out),
  .cfg_pending_out      (cfg_pending_out),
  .cfg_applied_out      (cfg_applied_out),
  .cfg_active_out       (cfg_active_out)
);
`default_nettype wire
